// File: hdl/irq_flag_pkg.sv
// constants for the interrupt enable and flag block
// assumes a word-indexed register bus of 9 address bits
package irq_flag_pkg;
  localparam int unsigned ADDR_W         = 9;
  localparam int unsigned DATA_W         = 8;
  localparam int unsigned BUS_W          = 32;
  // main control register, one alias per bank
  localparam logic [8:0]  IDX_MAIN_BANK0 = 9'h00B;
  localparam logic [8:0]  IDX_MAIN_BANK1 = 9'h08B;
  localparam logic [8:0]  IDX_MAIN_BANK2 = 9'h10B;
  localparam logic [8:0]  IDX_MAIN_BANK3 = 9'h18B;
  // second peripheral flags and their enables
  localparam logic [8:0]  IDX_PER_FLAG   = 9'h00D;
  localparam logic [8:0]  IDX_PER_ENABLE = 9'h00E;
  // main control fields
  localparam int unsigned GLOBAL_IRQ_ENABLE_BIT     = 7;
  localparam int unsigned PERIPH_IRQ_ENABLE_BIT     = 6;
  localparam int unsigned TIMER_ZERO_OVF_ENABLE_BIT = 5;
  localparam int unsigned EXT_PIN_IRQ_ENABLE_BIT    = 4;
  localparam int unsigned PORT_CHANGE_ENABLE_BIT    = 3;
  localparam int unsigned TIMER_ZERO_OVF_FLAG_BIT   = 2;
  localparam int unsigned EXT_PIN_IRQ_FLAG_BIT      = 1;
  localparam int unsigned PORT_CHANGE_FLAG_BIT      = 0;
  // second peripheral fields
  localparam int unsigned LOW_SUPPLY_FLAG_BIT       = 7;
  localparam int unsigned BUS_COLLISION_FLAG_BIT    = 3;
  localparam int unsigned CAPCMP_TWO_FLAG_BIT       = 0;
  localparam logic [7:0]  PER_IMPL_MASK  = 8'h89;
  // reset values
  localparam logic [7:0]  MAIN_RESET     = 8'h00;
  localparam logic [7:0]  PER_RESET      = 8'h00;
  localparam logic [7:0]  PER_EN_RESET   = 8'h00;
  // avalon response codes
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  // port pins watched for change
  localparam int unsigned PORT_WATCH_W   = 4;
endpackage : irq_flag_pkg

// File: hdl/irq_flag_cell.sv
// one software-visible bit that hardware may also set
// assumes write strobe already qualified by the bus slave
`timescale 1ns/1ns
module irq_flag_cell #(
  parameter logic RESET_VAL = 1'b0
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  // hardware and software sides
  input  wire logic set_i,
  input  wire logic wr_i,
  input  wire logic wdata_i,
  output logic      q_o
);
  // set wins over a software clear in the same cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_o <= RESET_VAL;
    end else if (ce_i) begin
      if (set_i) begin
        q_o <= 1'b1;
      end else if (wr_i) begin
        q_o <= wdata_i;
      end
    end
  end
endmodule : irq_flag_cell

// File: hdl/event_detect.sv
// turns sampled levels into one-cycle event pulses
// assumes inputs synchronous to clk_i
`timescale 1ns/1ns
module event_detect #(
  parameter int unsigned W         = 1,
  parameter logic        RISE_ONLY = 1'b1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         ce_i,
  // levels in, pulses out
  input  wire logic [W-1:0] lvl_i,
  output logic      [W-1:0] evt_o
);
  logic [W-1:0] prev_q;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_q <= '0;
    end else if (ce_i) begin
      prev_q <= lvl_i;
    end
  end

  always_comb begin
    if (RISE_ONLY) begin
      evt_o = lvl_i & ~prev_q;
    end else begin
      evt_o = lvl_i ^ prev_q;
    end
  end
endmodule : event_detect

// File: hdl/irq_enable_flag.sv
// interrupt enable and flag logic with an avalon-mm register slave
// assumes event inputs synchronous to clk_i, one pulse per event
//
// The Avalon-MM slave port was chosen for this implementation.
`timescale 1ns/1ns
module irq_enable_flag
  import irq_flag_pkg::*;
(
  // clock, reset, enable
  input  wire logic                    clk_i,
  input  wire logic                    rst_n_i,
  input  wire logic                    ce_i,
  // avalon-mm slave
  input  wire logic [ADDR_W-1:0]       address_i,
  input  wire logic                    read_i,
  input  wire logic                    write_i,
  input  wire logic [BUS_W-1:0]        writedata_i,
  output logic      [BUS_W-1:0]        readdata_o,
  output logic      [1:0]              response_o,
  output logic                         waitrequest_o,
  // event sources
  input  wire logic                    timer_zero_ovf_i,
  input  wire logic                    ext_irq_pin_i,
  input  wire logic [PORT_WATCH_W-1:0] port_upper_i,
  input  wire logic                    low_supply_i,
  input  wire logic                    bus_collision_i,
  input  wire logic                    capcmp_two_evt_i,
  input  wire logic                    capcmp_two_pwm_i,
  // request to the core
  output logic                         irq_o
);

  ////////////////////////////////////////////////////////////////////////
  // event pulses

  logic                    ext_evt;
  logic [PORT_WATCH_W-1:0] port_evt;
  logic                    port_any;
  logic                    capcmp_evt;

  event_detect #(.W(1), .RISE_ONLY(1'b1)) u_ext_edge (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .lvl_i   (ext_irq_pin_i),
    .evt_o   (ext_evt)
  );

  event_detect #(.W(PORT_WATCH_W), .RISE_ONLY(1'b0)) u_port_chg (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .ce_i    (ce_i),
    .lvl_i   (port_upper_i),
    .evt_o   (port_evt)
  );

  assign port_any   = |port_evt;
  assign capcmp_evt = capcmp_two_evt_i & ~capcmp_two_pwm_i;

  ////////////////////////////////////////////////////////////////////////
  // address decode and write strobes

  logic       hit_main;
  logic       hit_per;
  logic       hit_per_en;
  logic       hit_any;
  logic       accept;
  logic       wr_main;
  logic       wr_per;
  logic       wr_per_en;
  logic [7:0] wbyte;

  assign hit_main   = (address_i == IDX_MAIN_BANK0) || (address_i == IDX_MAIN_BANK1) ||
                      (address_i == IDX_MAIN_BANK2) || (address_i == IDX_MAIN_BANK3);
  assign hit_per    = (address_i == IDX_PER_FLAG);
  assign hit_per_en = (address_i == IDX_PER_ENABLE);
  assign hit_any    = hit_main | hit_per | hit_per_en;
  // transfer completes at the edge where waitrequest is low
  assign accept     = ce_i & ~waitrequest_o;
  assign wr_main    = accept & write_i & hit_main;
  assign wr_per     = accept & write_i & hit_per;
  assign wr_per_en  = accept & write_i & hit_per_en;
  assign wbyte      = writedata_i[DATA_W-1:0];

  ////////////////////////////////////////////////////////////////////////
  // main control register

  logic [7:0] set_main;
  logic [7:0] main_q;

  always_comb begin
    set_main = 8'h00;
    set_main[TIMER_ZERO_OVF_FLAG_BIT] = timer_zero_ovf_i;
    set_main[EXT_PIN_IRQ_FLAG_BIT]    = ext_evt;
    set_main[PORT_CHANGE_FLAG_BIT]    = port_any;
  end

  for (genvar i = 0; i < DATA_W; i++) begin : g_main
    irq_flag_cell #(.RESET_VAL(MAIN_RESET[i])) u_cell (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .ce_i    (ce_i),
      .set_i   (set_main[i]),
      .wr_i    (wr_main),
      .wdata_i (wbyte[i]),
      .q_o     (main_q[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // second peripheral flags and enables

  logic [7:0] set_per;
  logic [7:0] per_q;
  logic [7:0] per_en_q;

  always_comb begin
    set_per = 8'h00;
    set_per[LOW_SUPPLY_FLAG_BIT]    = low_supply_i;
    set_per[BUS_COLLISION_FLAG_BIT] = bus_collision_i;
    set_per[CAPCMP_TWO_FLAG_BIT]    = capcmp_evt;
  end

  for (genvar i = 0; i < DATA_W; i++) begin : g_per
    if (PER_IMPL_MASK[i]) begin : g_impl
      irq_flag_cell #(.RESET_VAL(PER_RESET[i])) u_cell (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .ce_i    (ce_i),
        .set_i   (set_per[i]),
        .wr_i    (wr_per),
        .wdata_i (wbyte[i]),
        .q_o     (per_q[i])
      );
    end else begin : g_unimpl
      assign per_q[i] = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      per_en_q <= PER_EN_RESET;
    end else if (wr_per_en) begin
      per_en_q <= wbyte & PER_IMPL_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus slave: one wait cycle, then the answer

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      waitrequest_o <= 1'b1;
    end else if (ce_i) begin
      waitrequest_o <= ~(waitrequest_o & (read_i | write_i));
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      readdata_o <= '0;
      response_o <= RESP_OKAY;
    end else if (ce_i && waitrequest_o && (read_i || write_i)) begin
      response_o <= hit_any ? RESP_OKAY : RESP_SLVERR;
      readdata_o <= '0;
      if (read_i && hit_main) begin
        readdata_o[DATA_W-1:0] <= main_q;
      end else if (read_i && hit_per) begin
        readdata_o[DATA_W-1:0] <= per_q;
      end else if (read_i && hit_per_en) begin
        readdata_o[DATA_W-1:0] <= per_en_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // request to the core

  logic core_pend;
  logic per_pend;
  logic irq_d;

  assign core_pend = (main_q[TIMER_ZERO_OVF_ENABLE_BIT] & main_q[TIMER_ZERO_OVF_FLAG_BIT]) |
                     (main_q[EXT_PIN_IRQ_ENABLE_BIT]    & main_q[EXT_PIN_IRQ_FLAG_BIT])    |
                     (main_q[PORT_CHANGE_ENABLE_BIT]    & main_q[PORT_CHANGE_FLAG_BIT]);
  assign per_pend  = main_q[PERIPH_IRQ_ENABLE_BIT] & |(per_en_q & per_q);
  assign irq_d     = main_q[GLOBAL_IRQ_ENABLE_BIT] & (core_pend | per_pend);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= irq_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  property p_timer_latch;
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && timer_zero_ovf_i |=> main_q[TIMER_ZERO_OVF_FLAG_BIT];
  endproperty
  a_timer_latch: assert property (p_timer_latch) else $error("timer flag not set");

  property p_ext_latch;
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && ext_irq_pin_i && !$past(ext_irq_pin_i) && $past(ce_i)
      |=> main_q[EXT_PIN_IRQ_FLAG_BIT];
  endproperty
  a_ext_latch: assert property (p_ext_latch) else $error("ext pin flag not set");

  property p_port_latch;
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && $past(ce_i) && (port_upper_i != $past(port_upper_i))
      |=> main_q[PORT_CHANGE_FLAG_BIT];
  endproperty
  a_port_latch: assert property (p_port_latch) else $error("port change flag not set");

  property p_low_supply;
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && low_supply_i |=> per_q[LOW_SUPPLY_FLAG_BIT] ##1 1'b1;
  endproperty
  a_low_supply: assert property (p_low_supply) else $error("low supply flag not set");

  property p_collision;
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && bus_collision_i && wr_per && !wbyte[BUS_COLLISION_FLAG_BIT]
      |=> per_q[BUS_COLLISION_FLAG_BIT];
  endproperty
  a_collision: assert property (p_collision) else $error("collision lost to clear");

  property p_capcmp_pwm;
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && capcmp_two_pwm_i && !per_q[CAPCMP_TWO_FLAG_BIT] && !wr_per
      |=> !per_q[CAPCMP_TWO_FLAG_BIT];
  endproperty
  a_capcmp_pwm: assert property (p_capcmp_pwm) else $error("capcmp flag set in pwm mode");

  property p_capcmp_set;
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && capcmp_two_evt_i && !capcmp_two_pwm_i |=> per_q[CAPCMP_TWO_FLAG_BIT];
  endproperty
  a_capcmp_set: assert property (p_capcmp_set) else $error("capcmp flag not set");

  property p_unimpl_zero;
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && waitrequest_o && read_i && hit_per
      |=> (readdata_o[6:4] == 3'h0) && (readdata_o[2:1] == 2'h0);
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero) else $error("unimplemented bits read one");

  property p_alias_write;
    @(posedge clk_i) disable iff (!rst_n_i)
    wr_main |=> main_q[7:3] == $past(wbyte[7:3]);
  endproperty
  a_alias_write: assert property (p_alias_write) else $error("alias write lost");

  property p_alias_read;
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && waitrequest_o && read_i && hit_main |=> readdata_o[7:0] == $past(main_q);
  endproperty
  a_alias_read: assert property (p_alias_read) else $error("alias read mismatch");

  property p_global_block;
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && !main_q[GLOBAL_IRQ_ENABLE_BIT] |=> !irq_o;
  endproperty
  a_global_block: assert property (p_global_block) else $error("request without global enable");

  property p_timer_req;
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && main_q[GLOBAL_IRQ_ENABLE_BIT] && main_q[TIMER_ZERO_OVF_ENABLE_BIT] &&
      main_q[TIMER_ZERO_OVF_FLAG_BIT] |=> irq_o;
  endproperty
  a_timer_req: assert property (p_timer_req) else $error("timer request missing");

  property p_periph_gate;
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && !main_q[PERIPH_IRQ_ENABLE_BIT] && !core_pend |=> !irq_o;
  endproperty
  a_periph_gate: assert property (p_periph_gate) else $error("peripheral request not gated");

  property p_wait_answer;
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && waitrequest_o && (read_i || write_i) |=> !waitrequest_o ##1 (waitrequest_o || !$past(ce_i));
  endproperty
  a_wait_answer: assert property (p_wait_answer) else $error("answer not after one wait cycle");

  property p_ext_req;
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && main_q[GLOBAL_IRQ_ENABLE_BIT] && main_q[EXT_PIN_IRQ_ENABLE_BIT] &&
      main_q[EXT_PIN_IRQ_FLAG_BIT] |=> irq_o;
  endproperty
  a_ext_req: assert property (p_ext_req) else $error("ext pin request missing");

  property p_port_req;
    @(posedge clk_i) disable iff (!rst_n_i)
    ce_i && main_q[GLOBAL_IRQ_ENABLE_BIT] && main_q[PORT_CHANGE_ENABLE_BIT] &&
      main_q[PORT_CHANGE_FLAG_BIT] |=> irq_o;
  endproperty
  a_port_req: assert property (p_port_req) else $error("port change request missing");

  // clock enable low holds every register
  property p_ce_freeze;
    @(posedge clk_i) disable iff (!rst_n_i)
    !ce_i |=> (main_q == $past(main_q)) && (per_q == $past(per_q)) &&
      (per_en_q == $past(per_en_q)) && (irq_o == $past(irq_o)) && (waitrequest_o == $past(waitrequest_o));
  endproperty
  a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with clock enable low");

  c_alias_write: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_main && address_i == IDX_MAIN_BANK3);
  c_set_beats_clear: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    wr_main && timer_zero_ovf_i && !wbyte[TIMER_ZERO_OVF_FLAG_BIT]);
  c_periph_req: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    !core_pend && per_pend ##1 irq_o);
  c_unmapped: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    accept && (read_i || write_i) && !hit_any);

endmodule : irq_enable_flag

// File: sim/event_source_model.sv
// model of the event sources feeding the interrupt flag block
// assumes the bench asks for events one clock ahead on fire_i
`timescale 1ns/1ns
module event_source_model
  import irq_flag_pkg::*;
(
  // clock and reset
  input  wire logic                    clk_i,
  input  wire logic                    rst_n_i,
  // bench requests: timer, pin, port, supply, collision, capture
  input  wire logic [5:0]              fire_i,
  // event lines
  output logic                         timer_zero_ovf_o,
  output logic                         ext_irq_pin_o,
  output logic      [PORT_WATCH_W-1:0] port_upper_o,
  output logic                         low_supply_o,
  output logic                         bus_collision_o,
  output logic                         capcmp_two_evt_o
);
  ////////////////////////////////////////////////////////////////////////
  // one event per requested cycle; pin returns low so it rises once
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      timer_zero_ovf_o <= 1'b0;
      ext_irq_pin_o    <= 1'b0;
      port_upper_o     <= '0;
      low_supply_o     <= 1'b0;
      bus_collision_o  <= 1'b0;
      capcmp_two_evt_o <= 1'b0;
    end else begin
      timer_zero_ovf_o <= fire_i[0];
      ext_irq_pin_o    <= fire_i[1];
      if (fire_i[2]) begin
        port_upper_o <= port_upper_o + 4'h1;
      end
      low_supply_o     <= fire_i[3];
      bus_collision_o  <= fire_i[4];
      capcmp_two_evt_o <= fire_i[5];
    end
  end
endmodule : event_source_model

// File: sim/irq_enable_flag_test.sv
// self-checking bench for the interrupt enable and flag block
// assumes one-cycle avalon answer and registered request output
`timescale 1ns/1ns
module irq_enable_flag_test;
  import irq_flag_pkg::*;
  logic                    clk_i, rst_n_i, ce_i, read_i, write_i, waitrequest_o, irq_o, pwm;
  logic                    tmr, ext, low, coll, cap;
  logic [ADDR_W-1:0]       address_i;
  logic [BUS_W-1:0]        writedata_i, readdata_o, rd;
  logic [1:0]              response_o, rsp;
  logic [PORT_WATCH_W-1:0] port;
  logic [5:0]              fire;
  logic [7:0]              m, en, pf;
  int                      n_errors, comparisons;
  logic [8:0] alias_q [4] = '{IDX_MAIN_BANK0, IDX_MAIN_BANK1, IDX_MAIN_BANK2, IDX_MAIN_BANK3};
  logic [8:0] ev_reg [6]  = '{IDX_MAIN_BANK0, IDX_MAIN_BANK1, IDX_MAIN_BANK2, IDX_PER_FLAG, IDX_PER_FLAG,
                              IDX_PER_FLAG};
  logic [7:0] ev_bit [6]  = '{8'h04, 8'h02, 8'h01, 8'h80, 8'h08, 8'h01};
  logic [7:0] cm [6]      = '{8'h24, 8'hA4, 8'h40, 8'hC0, 8'h92, 8'h89};

  irq_enable_flag irq_enable_flag_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .address_i(address_i), .read_i(read_i),
    .write_i(write_i), .writedata_i(writedata_i), .readdata_o(readdata_o), .response_o(response_o),
    .waitrequest_o(waitrequest_o), .timer_zero_ovf_i(tmr), .ext_irq_pin_i(ext), .port_upper_i(port),
    .low_supply_i(low), .bus_collision_i(coll), .capcmp_two_evt_i(cap), .capcmp_two_pwm_i(pwm),
    .irq_o(irq_o));

  event_source_model event_source_model_inst (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .fire_i(fire), .timer_zero_ovf_o(tmr), .ext_irq_pin_o(ext),
    .port_upper_o(port), .low_supply_o(low), .bus_collision_o(coll), .capcmp_two_evt_o(cap));

  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // request held until waitrequest seen low, bounded wait
  task automatic bus(input logic [8:0] a, input logic wr, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    address_i   <= a;
    read_i      <= ~wr;
    write_i     <= wr;
    writedata_i <= {24'h00_0000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (waitrequest_o !== 1'b0 && n < 20);
    rd = readdata_o;
    rsp = response_o;
    read_i  <= 1'b0;
    write_i <= 1'b0;
    if (waitrequest_o !== 1'b0) begin
      n_errors++;
      give_verdict();
    end
  endtask : bus

  task automatic pulse(input int k);
    fire[k] <= 1'b1;
    @(posedge clk_i);
    fire[k] <= 1'b0;
    repeat (3) @(posedge clk_i);
  endtask : pulse

  function automatic logic exp_irq(input logic [7:0] c, input logic [7:0] e, input logic [7:0] f);
    return c[7] & ((c[5] & c[2]) | (c[4] & c[1]) | (c[3] & c[0]) | (c[6] & (|(e & f & PER_IMPL_MASK))));
  endfunction : exp_irq

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n_i = 1'b0; ce_i = 1'b1; read_i = 1'b0; write_i = 1'b0; pwm = 1'b0; fire = '0;
    address_i = '0; writedata_i = '0; n_errors = 0; comparisons = 0;
    void'($urandom(83618));
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      bus(alias_q[i], 1'b0, 8'h00);
      check("main_reset", rd, 32'h0000_0000);
    end
    bus(IDX_PER_FLAG, 1'b0, 8'h00);
    check("per_reset", rd, 32'h0000_0000);
    bus(9'h1ff, 1'b0, 8'h00);
    check("unmapped_resp", 32'(rsp), 32'(RESP_SLVERR));
    for (int i = 0; i < 20; i++) begin
      m = 8'($urandom);
      en = 8'($urandom);
      pf = 8'($urandom);
      if (i < 6) begin
        m = cm[i]; en = 8'h01; pf = 8'h01;
      end
      bus(alias_q[i % 4], 1'b1, m);
      bus(IDX_PER_ENABLE, 1'b1, en);
      bus(IDX_PER_FLAG, 1'b1, pf);
      bus(alias_q[(i + 1) % 4], 1'b0, 8'h00);
      check("main_alias", rd, 32'(m));
      bus(IDX_PER_FLAG, 1'b0, 8'h00);
      check("per_flag", rd, 32'(pf & PER_IMPL_MASK));
      repeat (3) @(posedge clk_i);
      check("irq", 32'(irq_o), 32'(exp_irq(m, en, pf)));
    end
    bus(IDX_PER_ENABLE, 1'b1, 8'h00);
    for (int k = 0; k < 6; k++) begin
      bus(IDX_MAIN_BANK3, 1'b1, 8'h00);
      bus(IDX_PER_FLAG, 1'b1, 8'h00);
      pulse(k);
      bus(ev_reg[k], 1'b0, 8'h00);
      check("event_flag", rd, 32'(ev_bit[k]));
      check("irq_masked", 32'(irq_o), 32'h0000_0000);
    end
    bus(IDX_PER_FLAG, 1'b1, 8'h00);
    pwm <= 1'b1;
    pulse(5);
    bus(IDX_PER_FLAG, 1'b0, 8'h00);
    check("pwm_ignored", rd, 32'h0000_0000);
    pwm <= 1'b0;
    bus(IDX_MAIN_BANK0, 1'b1, 8'h00);
    bus(IDX_MAIN_BANK1, 1'b1, 8'hA0);
    fire[0] <= 1'b1;
    repeat (4) @(posedge clk_i);
    check("irq_timer", 32'(irq_o), 32'h0000_0001);
    bus(IDX_MAIN_BANK2, 1'b1, 8'hA0);
    bus(IDX_MAIN_BANK0, 1'b0, 8'h00);
    check("clear_race", rd, 32'h0000_00A4);
    fire <= 6'h10;
    bus(IDX_PER_FLAG, 1'b1, 8'h00);
    bus(IDX_PER_FLAG, 1'b0, 8'h00);
    check("collision_race", rd, 32'h0000_0008);
    fire <= 6'h00;
    bus(IDX_MAIN_BANK0, 1'b1, 8'hA0);
    repeat (3) @(posedge clk_i);
    check("irq_cleared", 32'(irq_o), 32'h0000_0000);
    ce_i <= 1'b0;
    pulse(0);
    ce_i <= 1'b1;
    bus(IDX_MAIN_BANK0, 1'b0, 8'h00);
    check("ce_frozen", rd, 32'h0000_00A0);
    check("irq_frozen", 32'(irq_o), 32'h0000_0000);
    give_verdict();
  end
endmodule : irq_enable_flag_test
